// File: src/core_timing_params.svh
// Constants for the instruction decode and timing block.
`ifndef CORE_TIMING_PARAMS_SVH
`define CORE_TIMING_PARAMS_SVH
`define SFR_SP_ADDR       8'h81
`define SFR_PTR_LOW_ADDR  8'h82
`define SFR_PTR_HIGH_ADDR 8'h83
`define PTR_LOW_RESET     8'h00
`define PTR_HIGH_RESET    8'h00
`define SP_RESET          8'h07
`define SPACE_SFR_BIT     7
`define UNUSED_OPCODE     8'hA5
`define CALL_PUSH_BYTES   8'h02
`endif

// File: src/core_timing_pkg.sv
// Types shared by the instruction decode and timing block.
package core_timing_pkg;
  typedef enum logic [4:0] {
    CL_OTHER = 5'b00000,
    CL_ACC   = 5'b00001,
    CL_CARRY = 5'b00010,
    CL_BIT   = 5'b00011,
    CL_CJMP  = 5'b00100,
    CL_BJMP  = 5'b00101,
    CL_PAGE  = 5'b00110,
    CL_FAR   = 5'b00111,
    CL_SHRT  = 5'b01000,
    CL_JMPI  = 5'b01001,
    CL_EXIT  = 5'b01010,
    CL_CMPJ  = 5'b01011,
    CL_DECJ  = 5'b01100,
    CL_PTRL  = 5'b01101,
    CL_CODE  = 5'b01110,
    CL_XMEM  = 5'b01111,
    CL_PUSH  = 5'b10000,
    CL_POP   = 5'b10001,
    CL_NIBX  = 5'b10010
  } class_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [2:0] cyc;
    class_t     cls;
  } dec_t;

  typedef struct packed {
    logic [1:0]  bytes;
    logic [2:0]  cycles;
    logic        taken;
    logic [15:0] target;
    logic [7:0]  acc;
    logic        carry;
    logic [7:0]  ram;
    logic        bit_wr;
    logic        bit_val;
    logic [7:0]  bank_addr;
    logic [7:0]  ptr_addr;
    logic        dir_sfr;
    logic [15:0] mem_addr;
  } res_t;
endpackage

// File: src/core_timing.sv
// Instruction decode, cycle timing and data pointer for the 8-bit core.
// Overview of operation
// RULE1: Accumulator clear, complement, rotate, swap: one cycle.
// RULE2: Register moves one cycle; direct or indirect two.
// RULE3: Direct-to-direct, immediate-to-direct, xor-immediate: three cycles.
// RULE4: Data pointer immediate load: three bytes, three cycles.
// RULE5: Code byte read at accumulator plus base.
// RULE6: External move uses 8 or 16-bit address.
// RULE7: Push and pop: two bytes, two cycles.
// RULE8: Nibble exchange swaps low nibbles, two cycles.
// RULE9: Carry ops one cycle; bit ops two.
// RULE10: Carry and zero jumps: two, three taken.
// RULE11: Bit jumps three or four; clear variant.
// RULE12: Paged target stays in current 2 kB page.
// RULE13: Far target 16 bits, four cycles.
// RULE14: Short and indirect jump three; exits five.
// RULE15: Compare-jump three/four or four/five cycles.
// RULE16: Decrement-jump two/three or three/four cycles.
// RULE17: Signed 8-bit offset from next instruction.
// RULE18: Direct address high half is special space.
// RULE19: Unused opcode behaves as idle opcode.
// RULE20: Bank register and indirect pointer selection.
// RULE21: Pointer pair bytes at 0x82, 0x83.
// RULE22: Software writes reserved bits with documented values.
// RULE23: Bank select places bank in low 32 bytes.
// RULE24: Stack pointer pre-increments on push, resets 0x07.
`include "core_timing_params.svh"
module core_timing
  import core_timing_pkg::*;
#(
  parameter int unsigned PC_W = 16
) (
  input  wire logic            I_MCLK,
  input  wire logic            I_SYS_RST,
  input  wire logic            I_ISSUE,
  input  wire logic [7:0]      I_OPCODE,
  input  wire logic [7:0]      I_OPERAND1,
  input  wire logic [7:0]      I_OPERAND2,
  input  wire logic [PC_W-1:0] I_NEXT_PC,
  input  wire logic [7:0]      I_ACC,
  input  wire logic            I_CARRY,
  input  wire logic            I_BIT_VALUE,
  input  wire logic [7:0]      I_SRC_VALUE,
  input  wire logic [7:0]      I_PTR_VALUE,
  input  wire logic [1:0]      I_BANK_SELECT,
  input  wire logic            I_SFR_WE,
  input  wire logic [7:0]      I_SFR_ADDR,
  input  wire logic [7:0]      I_SFR_WDATA,
  output logic                 O_READY,
  output logic                 O_DONE,
  output logic [1:0]           O_BYTES,
  output logic [2:0]           O_CYCLES,
  output logic                 O_TAKEN,
  output logic [15:0]          O_TARGET,
  output logic [7:0]           O_ACC_RESULT,
  output logic                 O_CARRY_RESULT,
  output logic [7:0]           O_RAM_RESULT,
  output logic                 O_BIT_WRITE,
  output logic                 O_BIT_RESULT,
  output logic [7:0]           O_BANK_ADDR,
  output logic [7:0]           O_PTR_ADDR,
  output logic                 O_DIRECT_IS_SFR,
  output logic [15:0]          O_MEM_ADDR,
  output logic [15:0]          O_PTR_PAIR,
  output logic [7:0]           O_SP,
  output logic [7:0]           O_SFR_RDATA
);

  function automatic dec_t mk(input logic [1:0] b, input logic [2:0] c, input class_t k);
    dec_t r;
    r.bytes = b;
    r.cyc   = c;
    r.cls   = k;
    return r;
  endfunction

  dec_t        dec;
  res_t        res_d, res_q;
  logic [2:0]  cnt_d, cnt_q;
  logic        done_d, done_q;
  logic        ready_d, ready_q;
  logic [7:0]  ptr_lo_d, ptr_lo_q;
  logic [7:0]  ptr_hi_d, ptr_hi_q;
  logic [7:0]  sp_d, sp_q;
  logic [7:0]  rdata_d, rdata_q;
  logic [15:0] ptr_pair;
  logic [15:0] rel_base;
  logic [7:0]  rel;
  logic [7:0]  cmp_a, cmp_b;
  logic [7:0]  dec_val;
  logic        cond;
  logic        accept;

  assign ptr_pair = {ptr_hi_q, ptr_lo_q};
  assign accept   = I_ISSUE & ready_q;

  // Opcode table: bytes, base cycles and class.
  always_comb begin
    dec = mk(2'h1, 3'h1, CL_OTHER);
    casez (I_OPCODE)
      // RULE1: accumulator single cycle.
      8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: dec = mk(2'h1, 3'h1, CL_ACC);
      // RULE2: register moves and exchange.
      8'b1110_1???, 8'b1111_1???, 8'b1100_1???: dec = mk(2'h1, 3'h1, CL_OTHER);
      // RULE2: direct and indirect moves.
      8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7: dec = mk(2'h1, 3'h2, CL_OTHER);
      8'hE5, 8'h74, 8'hF5, 8'hC5, 8'b1010_1???, 8'b0111_1???, 8'b1000_1???,
      8'h86, 8'h87, 8'hA6, 8'hA7, 8'h76, 8'h77: dec = mk(2'h2, 3'h2, CL_OTHER);
      // RULE3: three byte moves and xor-immediate.
      8'h85, 8'h75, 8'h63: dec = mk(2'h3, 3'h3, CL_OTHER);
      // RULE4: pointer pair load.
      8'h90: dec = mk(2'h3, 3'h3, CL_PTRL);
      // RULE5: code byte read.
      8'h93, 8'h83: dec = mk(2'h1, 3'h3, CL_CODE);
      // RULE6: external data move.
      8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3: dec = mk(2'h1, 3'h3, CL_XMEM);
      // RULE7: stack push and pop.
      8'hC0: dec = mk(2'h2, 3'h2, CL_PUSH);
      8'hD0: dec = mk(2'h2, 3'h2, CL_POP);
      // RULE8: nibble exchange.
      8'hD6, 8'hD7: dec = mk(2'h1, 3'h2, CL_NIBX);
      // RULE9: carry and bit operations.
      8'hC3, 8'hD3, 8'hB3: dec = mk(2'h1, 3'h1, CL_CARRY);
      8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: dec = mk(2'h2, 3'h2, CL_CARRY);
      8'hC2, 8'hD2, 8'hB2, 8'h92: dec = mk(2'h2, 3'h2, CL_BIT);
      // RULE10: carry and zero jumps.
      8'h40, 8'h50, 8'h60, 8'h70: dec = mk(2'h2, 3'h2, CL_CJMP);
      // RULE11: bit jumps.
      8'h20, 8'h30, 8'h10: dec = mk(2'h3, 3'h3, CL_BJMP);
      // RULE13: far call and jump.
      8'h12, 8'h02: dec = mk(2'h3, 3'h4, CL_FAR);
      // RULE14: exits, short and indirect jumps.
      8'h22, 8'h32: dec = mk(2'h1, 3'h5, CL_EXIT);
      8'h80: dec = mk(2'h2, 3'h3, CL_SHRT);
      8'h73: dec = mk(2'h1, 3'h3, CL_JMPI);
      // RULE15: compare and jump.
      8'hB5, 8'hB6, 8'hB7: dec = mk(2'h3, 3'h4, CL_CMPJ);
      8'hB4, 8'b1011_1???: dec = mk(2'h3, 3'h3, CL_CMPJ);
      // RULE16: decrement and jump.
      8'b1101_1???: dec = mk(2'h2, 3'h2, CL_DECJ);
      8'hD5: dec = mk(2'h3, 3'h3, CL_DECJ);
      // RULE19: unused opcode as idle.
      8'h00, `UNUSED_OPCODE: dec = mk(2'h1, 3'h1, CL_OTHER);
      // RULE12: paged call and jump.
      8'b???1_0001, 8'b???0_0001: dec = mk(2'h2, 3'h3, CL_PAGE);
      default: dec = mk(2'h1, 3'h1, CL_OTHER);
    endcase
  end

  // Operand helpers for branches and compares.
  always_comb begin
    rel_base = 16'(I_NEXT_PC);
    rel      = (dec.bytes == 2'h3) ? I_OPERAND2 : I_OPERAND1;
    cmp_a    = I_ACC;
    cmp_b    = I_OPERAND1;
    if (I_OPCODE == 8'hB5) begin
      cmp_b = I_SRC_VALUE;
    end else if (I_OPCODE != 8'hB4) begin
      cmp_a = I_SRC_VALUE;
    end
    dec_val = I_SRC_VALUE - 8'h01;
  end

  // Execution results and sequencing.
  always_comb begin
    res_d           = res_q;
    cond            = 1'b0;
    cnt_d           = (cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0;
    sp_d            = sp_q;
    ptr_lo_d        = ptr_lo_q;
    ptr_hi_d        = ptr_hi_q;
    if (I_SFR_WE) begin
      // RULE21: pointer bytes writable.
      if (I_SFR_ADDR == `SFR_PTR_LOW_ADDR) begin
        ptr_lo_d = I_SFR_WDATA;
      end else if (I_SFR_ADDR == `SFR_PTR_HIGH_ADDR) begin
        ptr_hi_d = I_SFR_WDATA;
      end else if (I_SFR_ADDR == `SFR_SP_ADDR) begin
        sp_d = I_SFR_WDATA;
      end
    end
    if (accept) begin
      res_d.bytes   = dec.bytes;
      res_d.taken   = 1'b0;
      res_d.target  = 16'h0000;
      res_d.acc     = I_ACC;
      res_d.carry   = I_CARRY;
      res_d.ram     = I_SRC_VALUE;
      res_d.bit_wr  = 1'b0;
      res_d.bit_val = I_BIT_VALUE;
      // RULE23: bank base from bank select.
      // RULE20: bank register and pointer.
      res_d.bank_addr = {3'b000, I_BANK_SELECT, I_OPCODE[2:0]};
      res_d.ptr_addr  = {3'b000, I_BANK_SELECT, 2'b00, I_OPCODE[0]};
      // RULE18: direct space select.
      res_d.dir_sfr  = I_OPERAND1[`SPACE_SFR_BIT];
      res_d.mem_addr = 16'h0000;
      case (dec.cls)
        CL_ACC: begin
          case (I_OPCODE)
            8'hE4: res_d.acc = 8'h00;
            8'hF4: res_d.acc = ~I_ACC;
            8'h23: res_d.acc = {I_ACC[6:0], I_ACC[7]};
            8'h33: begin
              res_d.acc   = {I_ACC[6:0], I_CARRY};
              res_d.carry = I_ACC[7];
            end
            8'h03: res_d.acc = {I_ACC[0], I_ACC[7:1]};
            8'h13: begin
              res_d.acc   = {I_CARRY, I_ACC[7:1]};
              res_d.carry = I_ACC[0];
            end
            default: res_d.acc = {I_ACC[3:0], I_ACC[7:4]};
          endcase
        end
        CL_CARRY: begin
          // RULE9: carry results.
          case (I_OPCODE)
            8'hC3:   res_d.carry = 1'b0;
            8'hD3:   res_d.carry = 1'b1;
            8'hB3:   res_d.carry = ~I_CARRY;
            8'h82:   res_d.carry = I_CARRY & I_BIT_VALUE;
            8'hB0:   res_d.carry = I_CARRY & ~I_BIT_VALUE;
            8'h72:   res_d.carry = I_CARRY | I_BIT_VALUE;
            8'hA0:   res_d.carry = I_CARRY | ~I_BIT_VALUE;
            default: res_d.carry = I_BIT_VALUE;
          endcase
        end
        CL_BIT: begin
          res_d.bit_wr = 1'b1;
          case (I_OPCODE)
            8'hC2:   res_d.bit_val = 1'b0;
            8'hD2:   res_d.bit_val = 1'b1;
            8'hB2:   res_d.bit_val = ~I_BIT_VALUE;
            default: res_d.bit_val = I_CARRY;
          endcase
        end
        CL_CJMP: begin
          // RULE10: jump condition.
          case (I_OPCODE[5:4])
            2'b00:   cond = I_CARRY;
            2'b01:   cond = ~I_CARRY;
            2'b10:   cond = (I_ACC == 8'h00);
            default: cond = (I_ACC != 8'h00);
          endcase
        end
        CL_BJMP: begin
          // RULE11: bit test and clear.
          cond = (I_OPCODE == 8'h30) ? ~I_BIT_VALUE : I_BIT_VALUE;
          if (I_OPCODE == 8'h10 && I_BIT_VALUE) begin
            res_d.bit_wr  = 1'b1;
            res_d.bit_val = 1'b0;
          end
        end
        // RULE15: unequal operands jump.
        CL_CMPJ: cond = (cmp_a != cmp_b);
        CL_DECJ: begin
          // RULE16: decremented value nonzero.
          res_d.ram = dec_val;
          cond      = (dec_val != 8'h00);
        end
        CL_PAGE: begin
          // RULE12: stay in current page.
          res_d.taken  = 1'b1;
          res_d.target = {rel_base[15:11], I_OPCODE[7:5], I_OPERAND1};
          if (I_OPCODE[4]) begin
            sp_d = sp_q + `CALL_PUSH_BYTES;
          end
        end
        CL_FAR: begin
          // RULE13: full 16-bit target.
          res_d.taken  = 1'b1;
          res_d.target = {I_OPERAND1, I_OPERAND2};
          if (I_OPCODE[4]) begin
            sp_d = sp_q + `CALL_PUSH_BYTES;
          end
        end
        CL_SHRT: begin
          res_d.taken = 1'b1;
        end
        CL_JMPI: begin
          // RULE14: indirect jump target.
          res_d.taken  = 1'b1;
          res_d.target = ptr_pair + {8'h00, I_ACC};
        end
        CL_EXIT: begin
          res_d.taken = 1'b1;
          sp_d        = sp_q - `CALL_PUSH_BYTES;
        end
        CL_PTRL: begin
          // RULE4: load pointer pair.
          ptr_hi_d = I_OPERAND1;
          ptr_lo_d = I_OPERAND2;
        end
        CL_CODE: begin
          // RULE5: code address base.
          res_d.mem_addr = (I_OPCODE[4] ? ptr_pair : rel_base) + {8'h00, I_ACC};
        end
        CL_XMEM: begin
          // RULE6: 8 or 16-bit address.
          res_d.mem_addr = I_OPCODE[1] ? {8'h00, I_PTR_VALUE} : ptr_pair;
        end
        CL_PUSH: begin
          // RULE24: increment before write.
          sp_d           = sp_q + 8'h01;
          res_d.mem_addr = {8'h00, sp_q + 8'h01};
        end
        CL_POP: begin
          sp_d           = sp_q - 8'h01;
          res_d.mem_addr = {8'h00, sp_q};
        end
        CL_NIBX: begin
          // RULE8: low nibbles only.
          res_d.acc = {I_ACC[7:4], I_SRC_VALUE[3:0]};
          res_d.ram = {I_SRC_VALUE[7:4], I_ACC[3:0]};
        end
        default: res_d.taken = 1'b0;
      endcase
      if (cond) begin
        res_d.taken = 1'b1;
      end
      if (cond || dec.cls == CL_SHRT) begin
        // RULE17: signed offset from next instruction.
        res_d.target = rel_base + {{8{rel[7]}}, rel};
      end
      res_d.cycles = dec.cyc + {2'b00, cond};
      cnt_d        = res_d.cycles;
    end
    done_d  = accept || (cnt_d == 3'h1 && cnt_q != 3'h1) ? (cnt_d == 3'h1) : 1'b0;
    ready_d = (cnt_d <= 3'h1);
    rdata_d = 8'h00;
    if (I_SFR_ADDR == `SFR_PTR_LOW_ADDR) begin
      rdata_d = ptr_lo_q;
    end else if (I_SFR_ADDR == `SFR_PTR_HIGH_ADDR) begin
      rdata_d = ptr_hi_q;
    end else if (I_SFR_ADDR == `SFR_SP_ADDR) begin
      rdata_d = sp_q;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      res_q    <= '0;
      cnt_q    <= 3'h0;
      done_q   <= 1'b0;
      ready_q  <= 1'b1;
      ptr_lo_q <= `PTR_LOW_RESET;
      ptr_hi_q <= `PTR_HIGH_RESET;
      sp_q     <= `SP_RESET;
      rdata_q  <= 8'h00;
    end else begin
      res_q    <= res_d;
      cnt_q    <= cnt_d;
      done_q   <= done_d;
      ready_q  <= ready_d;
      ptr_lo_q <= ptr_lo_d;
      ptr_hi_q <= ptr_hi_d;
      sp_q     <= sp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign O_READY         = ready_q;
  assign O_DONE          = done_q;
  assign O_BYTES         = res_q.bytes;
  assign O_CYCLES        = res_q.cycles;
  assign O_TAKEN         = res_q.taken;
  assign O_TARGET        = res_q.target;
  assign O_ACC_RESULT    = res_q.acc;
  assign O_CARRY_RESULT  = res_q.carry;
  assign O_RAM_RESULT    = res_q.ram;
  assign O_BIT_WRITE     = res_q.bit_wr;
  assign O_BIT_RESULT    = res_q.bit_val;
  assign O_BANK_ADDR     = res_q.bank_addr;
  assign O_PTR_ADDR      = res_q.ptr_addr;
  assign O_DIRECT_IS_SFR = res_q.dir_sfr;
  assign O_MEM_ADDR      = res_q.mem_addr;
  assign O_PTR_PAIR      = ptr_pair;
  assign O_SP            = sp_q;
  assign O_SFR_RDATA     = rdata_q;

endmodule

// File: verification/core_timing_sva.sv
// Assertion checker for the instruction decode and timing block.
module core_timing_sva
  import core_timing_pkg::*;
(
  input wire logic        I_MCLK,
  input wire logic        I_SYS_RST,
  input wire logic        I_ISSUE,
  input wire logic [7:0]  I_OPCODE,
  input wire logic [7:0]  I_OPERAND1,
  input wire logic [7:0]  I_OPERAND2,
  input wire logic        I_CARRY,
  input wire logic [1:0]  I_BANK_SELECT,
  input wire logic        I_SFR_WE,
  input wire logic [7:0]  I_SFR_ADDR,
  input wire logic [7:0]  I_SFR_WDATA,
  input wire logic        O_READY,
  input wire logic        O_DONE,
  input wire logic [2:0]  O_CYCLES,
  input wire logic        O_TAKEN,
  input wire logic [15:0] O_TARGET,
  input wire logic [7:0]  O_ACC_RESULT,
  input wire logic [7:0]  O_BANK_ADDR,
  input wire logic        O_DIRECT_IS_SFR,
  input wire logic [15:0] O_PTR_PAIR,
  input wire logic [7:0]  O_SP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  logic       take;
  logic       op1_msb;
  logic [2:0] reg_sel;
  assign take = I_ISSUE && O_READY;
  assign op1_msb = I_OPERAND1[7];
  assign reg_sel = I_OPCODE[2:0];
  sequence done_after3;
    !O_DONE [*2] ##1 O_DONE;
  endsequence
  sequence done_after4;
    !O_DONE [*3] ##1 O_DONE;
  endsequence
  sequence done_after5;
    !O_DONE [*4] ##1 O_DONE;
  endsequence
  idle_one_cycle_a: assert property (
    take && I_OPCODE inside {8'h00, 8'hA5} |=> O_DONE && O_CYCLES == 3'd1 && !O_TAKEN)
    else $error("idle opcode timing wrong");
  clear_acc_a: assert property (
    take && I_OPCODE == 8'hE4 |=> O_DONE && O_ACC_RESULT == 8'h00)
    else $error("accumulator clear wrong");
  pointer_load_a: assert property (
    take && I_OPCODE == 8'h90 |=> done_after3)
    else $error("pointer load not three cycles");
  far_jump_a: assert property (
    take && I_OPCODE == 8'h02 |=> O_TARGET == {$past(I_OPERAND1), $past(I_OPERAND2)} ##0 done_after4)
    else $error("far jump target or timing wrong");
  exit_five_a: assert property (
    take && I_OPCODE inside {8'h22, 8'h32} |=> done_after5)
    else $error("exit not five cycles");
  carry_jump_a: assert property (
    take && I_OPCODE == 8'h40 && !I_CARRY |=> !O_TAKEN && O_CYCLES == 3'd2 && !O_DONE ##1 O_DONE)
    else $error("untaken carry jump timing wrong");
  direct_space_a: assert property (
    take |=> O_DIRECT_IS_SFR == $past(op1_msb))
    else $error("direct space select wrong");
  bank_addr_a: assert property (
    take && I_OPCODE[7:3] == 5'h1D |=> O_BANK_ADDR == {3'b000, $past(I_BANK_SELECT), $past(reg_sel)})
    else $error("bank register address wrong");
  ptr_low_write_a: assert property (
    I_SFR_WE && I_SFR_ADDR == 8'h82 && O_READY && !I_ISSUE |=> O_PTR_PAIR[7:0] == $past(I_SFR_WDATA))
    else $error("pointer low write lost");
  reset_values_a: assert property (
    $fell(I_SYS_RST) |-> O_SP == 8'h07 && O_PTR_PAIR == 16'h0000 && O_READY)
    else $error("reset values wrong");
endmodule
bind core_timing core_timing_sva chk_u (
  .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ISSUE(I_ISSUE), .I_OPCODE(I_OPCODE),
  .I_OPERAND1(I_OPERAND1), .I_OPERAND2(I_OPERAND2), .I_CARRY(I_CARRY),
  .I_BANK_SELECT(I_BANK_SELECT), .I_SFR_WE(I_SFR_WE), .I_SFR_ADDR(I_SFR_ADDR),
  .I_SFR_WDATA(I_SFR_WDATA), .O_READY(O_READY), .O_DONE(O_DONE), .O_CYCLES(O_CYCLES),
  .O_TAKEN(O_TAKEN), .O_TARGET(O_TARGET), .O_ACC_RESULT(O_ACC_RESULT),
  .O_BANK_ADDR(O_BANK_ADDR), .O_DIRECT_IS_SFR(O_DIRECT_IS_SFR),
  .O_PTR_PAIR(O_PTR_PAIR), .O_SP(O_SP));

// File: verification/tb.sv
// Self-checking bench for the instruction decode and timing block.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, sys_rst, issue, carry, bit_v, sfr_we;
  logic [7:0]  opc, op1, op2, acc, src, ptr, sfr_addr, sfr_wdata;
  logic [15:0] npc;
  logic [1:0]  bank;
  logic        ready, done, taken, cy_r, bit_wr, bit_r, is_sfr;
  logic [1:0]  bytes;
  logic [2:0]  cycles;
  logic [15:0] target, mem_addr, pair, dp_m;
  logic [7:0]  acc_r, ram_r, bank_a, ptr_a, sp, rdata, sp_m;
  logic [31:0] rs;
  int          fail_count, n_checks;
  // Each entry is opcode, byte count, untaken cycle count.
  logic [15:0] tbl [$] = '{16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
    16'hC411, 16'hE911, 16'hE522, 16'hE712, 16'h8533, 16'h7533, 16'h6333, 16'h9033,
    16'h9313, 16'h8313, 16'hE213, 16'hF013, 16'hC022, 16'hD022, 16'hD612, 16'hC811,
    16'hC311, 16'hD311, 16'hB311, 16'hC222, 16'hB022, 16'h9222, 16'h4022, 16'h5022,
    16'h6022, 16'h7022, 16'h2033, 16'h3033, 16'h1033, 16'h1123, 16'h0123, 16'h1234,
    16'h0234, 16'h8023, 16'h7313, 16'h2215, 16'h3215, 16'hB534, 16'hB433, 16'hBA33,
    16'hB634, 16'hDB22, 16'hD533, 16'h0011, 16'hA511, 16'h7222, 16'hD222};
  core_timing dut_u (.I_MCLK(mclk), .I_SYS_RST(sys_rst), .I_ISSUE(issue), .I_OPCODE(opc),
    .I_OPERAND1(op1), .I_OPERAND2(op2), .I_NEXT_PC(npc), .I_ACC(acc), .I_CARRY(carry),
    .I_BIT_VALUE(bit_v), .I_SRC_VALUE(src), .I_PTR_VALUE(ptr), .I_BANK_SELECT(bank),
    .I_SFR_WE(sfr_we), .I_SFR_ADDR(sfr_addr), .I_SFR_WDATA(sfr_wdata), .O_READY(ready),
    .O_DONE(done), .O_BYTES(bytes), .O_CYCLES(cycles), .O_TAKEN(taken), .O_TARGET(target),
    .O_ACC_RESULT(acc_r), .O_CARRY_RESULT(cy_r), .O_RAM_RESULT(ram_r),
    .O_BIT_WRITE(bit_wr), .O_BIT_RESULT(bit_r), .O_BANK_ADDR(bank_a), .O_PTR_ADDR(ptr_a),
    .O_DIRECT_IS_SFR(is_sfr), .O_MEM_ADDR(mem_addr), .O_PTR_PAIR(pair), .O_SP(sp),
    .O_SFR_RDATA(rdata));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Returns whether the opcode is conditional, and whether it branches.
  function automatic logic [1:0] cnd(input logic [7:0] o);
    case (o)
      8'h40: return {1'b1, carry};
      8'h50: return {1'b1, !carry};
      8'h60: return {1'b1, acc == 8'h00};
      8'h70: return {1'b1, acc != 8'h00};
      8'h20, 8'h10: return {1'b1, bit_v};
      8'h30: return {1'b1, !bit_v};
      8'hB5: return {1'b1, acc != src};
      8'hB4: return {1'b1, acc != op1};
      8'hB6, 8'hBA: return {1'b1, src != op1};
      8'hDB, 8'hD5: return {1'b1, src != 8'h01};
      default: return 2'b00;
    endcase
  endfunction
  // Returns a valid flag and the expected accumulator result.
  function automatic logic [8:0] exa(input logic [7:0] o);
    case (o)
      8'hE4: return 9'h100;
      8'hF4: return {1'b1, ~acc};
      8'h23: return {1'b1, acc[6:0], acc[7]};
      8'h03: return {1'b1, acc[0], acc[7:1]};
      8'h33: return {1'b1, acc[6:0], carry};
      8'h13: return {1'b1, carry, acc[7:1]};
      8'hC4: return {1'b1, acc[3:0], acc[7:4]};
      8'hD6: return {1'b1, acc[7:4], src[3:0]};
      default: return 9'h000;
    endcase
  endfunction
  // Returns carry valid, carry, bit write valid and written bit.
  function automatic logic [3:0] exb(input logic [7:0] o);
    case (o)
      8'hC3: return 4'b1000;
      8'hD3: return 4'b1100;
      8'hB3: return {1'b1, !carry, 2'b00};
      8'hB0: return {1'b1, carry & !bit_v, 2'b00};
      8'h72: return {1'b1, carry | bit_v, 2'b00};
      8'h33: return {1'b1, acc[7], 2'b00};
      8'h13: return {1'b1, acc[0], 2'b00};
      8'hC2: return 4'b0010;
      8'hD2: return 4'b0011;
      8'h92: return {2'b00, 1'b1, carry};
      8'h10: return {2'b00, bit_v, 1'b0};
      default: return 4'b0000;
    endcase
  endfunction
  task automatic run(input logic [15:0] e);
    logic [1:0] c;
    logic [8:0] a;
    logic [7:0] rel;
    logic [2:0] ex;
    logic [3:0] n4;
    logic [3:0] b;
    rs = xs(rs);
    {op1, op2, acc, src} = rs;
    rs = xs(rs);
    {npc, ptr, carry, bit_v, bank} = rs[27:0];
    if (rs[28]) acc = 8'h00;
    if (rs[29]) src = op1;
    if (rs[30]) src = 8'h01;
    if (rs[31]) acc = src;
    opc = e[15:8];
    issue = 1'b1;
    @(negedge mclk);
    issue = 1'b0;
    n4 = 4'd1;
    while (done !== 1'b1 && n4 < 4'd9) begin
      @(negedge mclk);
      n4++;
    end
    c = cnd(opc);
    a = exa(opc);
    b = exb(opc);
    ex = e[2:0] + {2'b00, c[0]};
    rel = (e[5:4] == 2'd3) ? op2 : op1;
    if (opc == 8'h90) dp_m = {op1, op2};
    if (opc inside {8'h11, 8'h12}) sp_m += 8'h02;
    if (opc inside {8'h22, 8'h32}) sp_m -= 8'h02;
    if (opc == 8'hC0) sp_m += 8'h01;
    if (opc == 8'hD0) sp_m -= 8'h01;
    `CHK(n4, {1'b0, ex})
    `CHK(cycles, ex)
    `CHK(bytes, e[5:4])
    if (c[1]) `CHK(taken, c[0])
    if (c[0] || opc == 8'h80) `CHK(target, npc + {{8{rel[7]}}, rel})
    if (opc inside {8'h01, 8'h11}) `CHK(target, {npc[15:11], opc[7:5], op1})
    if (opc inside {8'h02, 8'h12}) `CHK(target, {op1, op2})
    if (opc == 8'h73) `CHK(target, dp_m + {8'h00, acc})
    if (a[8]) `CHK(acc_r, a[7:0])
    if (b[3]) `CHK(cy_r, b[2])
    if (b[1]) `CHK({bit_wr, bit_r}, {1'b1, b[0]})
    if (opc == 8'hD6) `CHK(ram_r, {src[7:4], acc[3:0]})
    if (opc inside {8'hDB, 8'hD5}) `CHK(ram_r, src - 8'h01)
    if (opc == 8'h10) `CHK(bit_wr, bit_v)
    if (opc == 8'h93) `CHK(mem_addr, dp_m + {8'h00, acc})
    if (opc == 8'h83) `CHK(mem_addr, npc + {8'h00, acc})
    if (opc == 8'hE2) `CHK(mem_addr, {8'h00, ptr})
    if (opc == 8'hF0) `CHK(mem_addr, dp_m)
    if (opc == 8'hC0) `CHK(mem_addr[7:0], sp_m)
    if (opc inside {8'hE7, 8'hE2, 8'hD6, 8'hB6}) `CHK(ptr_a, {3'b000, bank, 2'b00, opc[0]})
    if (opc inside {8'hE9, 8'hC8, 8'hBA, 8'hDB}) `CHK(bank_a, {3'b000, bank, opc[2:0]})
    if (opc == 8'hE5) `CHK(is_sfr, op1[7])
    `CHK(pair, dp_m)
    `CHK(sp, sp_m)
  endtask
  task automatic special_function_space(input logic [7:0] a, input logic [7:0] d, input logic wr);
    sfr_we = wr;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge mclk);
    sfr_we = 1'b0;
    if (!wr) `CHK(rdata, d)
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {issue, carry, bit_v, sfr_we, opc, op1, op2, acc, src, ptr, npc, bank} = '0;
    {sfr_addr, sfr_wdata} = '0;
    sys_rst = 1'b1;
    rs = 32'h0000_D396;
    fail_count = 0;
    n_checks = 0;
    dp_m = 16'h0000;
    sp_m = 8'h07;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    `CHK(sp, 8'h07)
    special_function_space(8'h82, 8'h00, 1'b0);
    special_function_space(8'h83, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      special_function_space(8'h81 + i[7:0], rs[7:0], 1'b1);
      special_function_space(8'h81 + i[7:0], (i == 3) ? 8'h00 : rs[7:0], 1'b0);
      if (i == 0) sp_m = rs[7:0];
      if (i == 1) dp_m[7:0] = rs[7:0];
      if (i == 2) dp_m[15:8] = rs[7:0];
    end
    `CHK(pair, dp_m)
    $display("test register access done");
    repeat (8) foreach (tbl[i]) run(tbl[i]);
    $display("test instruction timing done");
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    dp_m = 16'h0000;
    sp_m = 8'h07;
    `CHK(ready, 1'b1)
    run(16'h0234);
    $display("test second reset done");
    summarize;
  end
  // Instruction loop needs under two thousand cycles; stop well beyond that.
  initial begin
    #40000;
    fail_count++;
    $display("mismatch t=%0t watchdog expired", $time);
    summarize;
  end
endmodule
